/* File: design/pciw_pkg.sv */
// Shared constants and types for the card I/O width translator
package pciw_pkg;

   // Register offsets on the plain register port, and the width register reset value
   localparam logic [7:0] REG_WIDTH_OFS = 8'h0A;
   localparam logic [7:0] REG_STAT_OFS = 8'h10;
   localparam logic [7:0] REG_WIDTH_RST = 8'h00;

   // Data width register fields
   localparam int SEL_A_HI_BIT = 7;
   localparam int SEL_A_LO_BIT = 6;
   localparam int SEL_B_HI_BIT = 5;
   localparam int SEL_B_LO_BIT = 4;
   localparam int B_ACCEPT_BIT = 3;
   localparam int A_ACCEPT_BIT = 2;

   // Status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SOCK_BIT = 1;
   localparam int STAT_SPLIT_BIT = 2;
   localparam int STAT_ERR_BIT = 3;
   localparam int STAT_WIDE_A_BIT = 4;
   localparam int STAT_WIDE_B_BIT = 5;

   // Only legal selector: upper bit 1, lower bit 0
   localparam logic [1:0] SEL_VALID = 2'h2;

   // Card cycle timing
   localparam int CLK_NS = 20;
   localparam int STROBE_NS = 200;
   localparam int GAP_NS = 40;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;

   localparam logic [15:0] DATA_ZERO = 16'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      PCIW_IDLE,
      PCIW_CYC,
      PCIW_GAP
   } pciw_state_t;

   typedef enum logic [1:0] {
      PCIW_M_BYTE_LO,
      PCIW_M_BYTE_HI,
      PCIW_M_WORD,
      PCIW_M_SPLIT
   } pciw_mode_t;

   // System access request
   typedef struct packed {
      logic req;
      logic sock;
      logic wide;
      logic write;
      logic sys_addr_bit_zero;
      logic sys_byte_high_enable_b;
      logic [15:0] wdata;
   } pciw_acc_t;

   // Card-side drive, all strobes active low
   typedef struct packed {
      logic sock_a_low_byte_enable_b;
      logic sock_a_high_byte_enable_b;
      logic sock_b_low_byte_enable_b;
      logic sock_b_high_byte_enable_b;
      logic iord_b;
      logic iowr_b;
      logic addr_bit_zero;
      logic [15:0] wdata;
   } pciw_card_t;

   localparam pciw_card_t CARD_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0000};

endpackage : pciw_pkg

/* File: design/pciw_top.sv */
// Card I/O width translator: system I/O accesses to card byte/word cycles
// Notes on behaviour
// - A, 8-bit, wide-io low: even uses low enable, odd high enable.
// - A, 8-bit, wide-io high: low enable only, any address.
// - A, 16-bit, wide-io low: one word cycle, both enables.
// - Word card cycle only when address bit zero and byte-high enable both 0.
// - A, 16-bit, wide-io high: two byte cycles on low enable.
// - B, 8-bit, wide-io low: even uses low enable, odd high enable.
// - B, 8-bit, wide-io high: low enable only, any address.
// - B, 16-bit, wide-io low: one word cycle, both enables.
// - B, 16-bit, wide-io high: two byte cycles on low enable.
// - Socket A accept bit 0: split every 16-bit access.
// - Socket B accept bit 0: split every 16-bit access.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

module pciw_top #(
   parameter int STROBE_CYCLES = pciw_pkg::STROBE_CYC,
   parameter int GAP_CYCLES = pciw_pkg::GAP_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // System access port
   input wire pciw_pkg::pciw_acc_t i_acc,
   output logic o_acc_ready,
   output logic o_acc_done,
   output logic o_acc_err,
   output logic [15:0] o_acc_rdata,
   // Card side
   input wire logic i_sock_a_card_wide_io,
   input wire logic i_sock_b_card_wide_io,
   input wire logic [15:0] i_card_rdata,
   output pciw_pkg::pciw_card_t o_card
);

   typedef struct packed {
      // Access engine; mode, sock, write and wdata are frozen at the take
      pciw_pkg::pciw_state_t st;
      pciw_pkg::pciw_mode_t mode;
      logic [pciw_pkg::CNT_W-1:0] cnt;
      logic sock;
      logic write;
      logic phase;
      logic [15:0] wdata;
      logic [15:0] rdata;
      // Register side
      logic [7:0] width;
      logic err;
      logic done;
      logic acc_err;
      logic [7:0] reg_rdata;
      // Card drive, registered so strobes never glitch
      pciw_pkg::pciw_card_t card;
   } pciw_regs_t;

   // Counters load N-1 and stop at zero, so a count of N spans N cycles
   localparam logic [pciw_pkg::CNT_W-1:0] STROBE_LAST = pciw_pkg::CNT_W'(STROBE_CYCLES - 1);
   localparam logic [pciw_pkg::CNT_W-1:0] GAP_LAST = pciw_pkg::CNT_W'(GAP_CYCLES - 1);
   localparam logic [pciw_pkg::CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [pciw_pkg::CNT_W-1:0] CNT_ONE = pciw_pkg::CNT_W'(1);

   localparam pciw_regs_t REGS_RST = '{
      st: pciw_pkg::PCIW_IDLE,
      mode: pciw_pkg::PCIW_M_BYTE_LO,
      cnt: '0,
      sock: 1'b0,
      write: 1'b0,
      phase: 1'b0,
      wdata: pciw_pkg::DATA_ZERO,
      rdata: pciw_pkg::DATA_ZERO,
      width: pciw_pkg::REG_WIDTH_RST,
      err: 1'b0,
      done: 1'b0,
      acc_err: 1'b0,
      reg_rdata: pciw_pkg::BYTE_ZERO,
      card: pciw_pkg::CARD_IDLE
   };

   logic [1:0] rst_sync_q;
   logic rst_b;
   pciw_regs_t q;
   pciw_regs_t d;

   // Reset released through two flops
   // Assert is immediate; release is clocked to avoid a half-reset state
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_q[1];

   // Builds the card drive for one cycle of the current access
   function automatic pciw_pkg::pciw_card_t drive(input logic sock, input pciw_pkg::pciw_mode_t mode,
                                                  input logic phase, input logic write, input logic addr0,
                                                  input logic [15:0] wdata);
      pciw_pkg::pciw_card_t c;
      logic lo;
      logic hi;
      c = pciw_pkg::CARD_IDLE;
      lo = 1'b0;
      hi = 1'b0;
      c.iord_b = write;
      c.iowr_b = !write;
      unique case (mode)
         pciw_pkg::PCIW_M_BYTE_LO: begin
            lo = 1'b1;
            c.addr_bit_zero = addr0;
            c.wdata = {pciw_pkg::BYTE_ZERO, wdata[7:0]};
         end

         pciw_pkg::PCIW_M_BYTE_HI: begin
            // Odd byte travels on the high lane
            hi = 1'b1;
            c.addr_bit_zero = addr0;
            c.wdata = {wdata[7:0], pciw_pkg::BYTE_ZERO};
         end

         pciw_pkg::PCIW_M_WORD: begin
            lo = 1'b1;
            hi = 1'b1;
            c.addr_bit_zero = 1'b0;
            c.wdata = wdata;
         end

         pciw_pkg::PCIW_M_SPLIT: begin
            // Low byte at even address first, high byte at odd address second
            lo = 1'b1;
            c.addr_bit_zero = phase;
            c.wdata = {pciw_pkg::BYTE_ZERO, phase ? wdata[15:8] : wdata[7:0]};
         end
      endcase
      c.sock_a_low_byte_enable_b = !(lo && !sock);
      c.sock_a_high_byte_enable_b = !(hi && !sock);
      c.sock_b_low_byte_enable_b = !(lo && sock);
      c.sock_b_high_byte_enable_b = !(hi && sock);
      return c;
   endfunction : drive

   always_comb begin
      logic [1:0] sel;
      logic accept;
      logic wide_io;
      logic even;
      pciw_pkg::pciw_mode_t mode;
      sel = 2'h0;
      accept = 1'b0;
      wide_io = 1'b0;
      even = 1'b0;
      mode = pciw_pkg::PCIW_M_BYTE_LO;
      // Pulses and register read data default low; everything else holds
      d = q;
      d.done = 1'b0;
      d.acc_err = 1'b0;
      d.reg_rdata = pciw_pkg::BYTE_ZERO;

      // Read data registered and zero outside a read
      if (i_reg_rd) begin
         if (i_reg_addr == pciw_pkg::REG_WIDTH_OFS) begin
            d.reg_rdata = q.width;
         end else if (i_reg_addr == pciw_pkg::REG_STAT_OFS) begin
            d.reg_rdata[pciw_pkg::STAT_BUSY_BIT] = (q.st != pciw_pkg::PCIW_IDLE);
            d.reg_rdata[pciw_pkg::STAT_SOCK_BIT] = q.sock;
            d.reg_rdata[pciw_pkg::STAT_SPLIT_BIT] = (q.mode == pciw_pkg::PCIW_M_SPLIT);
            d.reg_rdata[pciw_pkg::STAT_ERR_BIT] = q.err;
            d.reg_rdata[pciw_pkg::STAT_WIDE_A_BIT] = i_sock_a_card_wide_io;
            d.reg_rdata[pciw_pkg::STAT_WIDE_B_BIT] = i_sock_b_card_wide_io;
         end
      end
      // A width write applies from the next request; one in flight keeps its decision
      if (i_reg_wr) begin
         if (i_reg_addr == pciw_pkg::REG_WIDTH_OFS) begin
            d.width = i_reg_wdata;
         end else if (i_reg_addr == pciw_pkg::REG_STAT_OFS && i_reg_wdata[pciw_pkg::STAT_ERR_BIT]) begin
            d.err = 1'b0;
         end
      end

      // Access engine
      unique case (q.st)
         pciw_pkg::PCIW_IDLE: begin
            if (i_acc.req) begin
               // Card line read only here; later swings cannot change the access
               if (i_acc.sock) begin
                  sel = {q.width[pciw_pkg::SEL_B_HI_BIT], q.width[pciw_pkg::SEL_B_LO_BIT]};
                  accept = q.width[pciw_pkg::B_ACCEPT_BIT];
                  wide_io = i_sock_b_card_wide_io;
               end else begin
                  sel = {q.width[pciw_pkg::SEL_A_HI_BIT], q.width[pciw_pkg::SEL_A_LO_BIT]};
                  accept = q.width[pciw_pkg::A_ACCEPT_BIT];
                  wide_io = i_sock_a_card_wide_io;
               end
               even = !i_acc.sys_addr_bit_zero && !i_acc.sys_byte_high_enable_b;

               if (!i_acc.wide) begin
                  if (wide_io || !i_acc.sys_addr_bit_zero) begin
                     mode = pciw_pkg::PCIW_M_BYTE_LO;
                  end else begin
                     mode = pciw_pkg::PCIW_M_BYTE_HI;
                  end
               end else if (!wide_io && accept && even) begin
                  mode = pciw_pkg::PCIW_M_WORD;
               end else begin
                  mode = pciw_pkg::PCIW_M_SPLIT;
               end
               if (sel != pciw_pkg::SEL_VALID) begin
                  // Bad selector: refuse with no card cycle; set beats a same-cycle clear
                  d.err = 1'b1;
                  d.done = 1'b1;
                  d.acc_err = 1'b1;
               end else begin
                  // Decision frozen here for the whole access
                  d.mode = mode;
                  d.sock = i_acc.sock;
                  d.write = i_acc.write;
                  d.wdata = i_acc.wdata;
                  d.phase = 1'b0;
                  d.rdata = pciw_pkg::DATA_ZERO;
                  d.cnt = STROBE_LAST;
                  d.card = drive(i_acc.sock, mode, 1'b0, i_acc.write, i_acc.sys_addr_bit_zero, i_acc.wdata);
                  d.st = pciw_pkg::PCIW_CYC;
               end
            end
         end

         pciw_pkg::PCIW_CYC: begin
            if (q.cnt != CNT_ZERO) begin
               d.cnt = q.cnt - CNT_ONE;
            end else begin
               // Card data taken in the last strobe cycle, while it still stands
               unique case (q.mode)
                  pciw_pkg::PCIW_M_BYTE_LO: begin
                     d.rdata[7:0] = i_card_rdata[7:0];
                  end
                  pciw_pkg::PCIW_M_BYTE_HI: begin
                     // Odd byte returns on the high lane, handed back in the low byte
                     d.rdata[7:0] = i_card_rdata[15:8];
                  end
                  pciw_pkg::PCIW_M_WORD: begin
                     d.rdata = i_card_rdata;
                  end
                  pciw_pkg::PCIW_M_SPLIT: begin
                     if (q.phase) begin
                        d.rdata[15:8] = i_card_rdata[7:0];
                     end else begin
                        d.rdata[7:0] = i_card_rdata[7:0];
                     end
                  end
               endcase
               d.card = pciw_pkg::CARD_IDLE;
               if (q.mode == pciw_pkg::PCIW_M_SPLIT && !q.phase) begin
                  d.cnt = GAP_LAST;
                  d.st = pciw_pkg::PCIW_GAP;
               end else begin
                  d.done = 1'b1;
                  d.st = pciw_pkg::PCIW_IDLE;
               end
            end
         end

         pciw_pkg::PCIW_GAP: begin
            if (q.cnt != CNT_ZERO) begin
               d.cnt = q.cnt - CNT_ONE;
            end else begin
               // Second byte always at the odd address, still on the low enable
               d.phase = 1'b1;
               d.cnt = STROBE_LAST;
               d.card = drive(q.sock, q.mode, 1'b1, q.write, 1'b1, q.wdata);
               d.st = pciw_pkg::PCIW_CYC;
            end
         end

         default: begin
            d.card = pciw_pkg::CARD_IDLE;
            d.st = pciw_pkg::PCIW_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.reg_rdata;
   // Ready straight from state, so a new request may be taken with done
   assign o_acc_ready = (q.st == pciw_pkg::PCIW_IDLE);
   assign o_acc_done = q.done;
   assign o_acc_err = q.acc_err;
   assign o_acc_rdata = q.rdata;
   assign o_card = q.card;

endmodule : pciw_top

/* File: dv/pciw_top_monitor.sv */
// Assertion checker for the card I/O width translator
`timescale 1ns/1ps
module pciw_top_monitor #(
   parameter int STROBE_CYCLES = pciw_pkg::STROBE_CYC,
   parameter int GAP_CYCLES = pciw_pkg::GAP_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire pciw_pkg::pciw_acc_t i_acc,
   input wire logic o_acc_ready,
   input wire logic o_acc_done,
   input wire logic o_acc_err,
   input wire logic i_sock_a_card_wide_io,
   input wire logic i_sock_b_card_wide_io,
   input wire pciw_pkg::pciw_card_t o_card
);
   localparam int T1 = STROBE_CYCLES + 1;
   logic [7:0] width_q;
   logic [3:0] en4, exp4, exp_q;
   logic [1:0] sel, pair;
   logic acc16, wio, valid, word, split, take;
   // Shadow of the width register, so selector checks need no internal probes
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         width_q <= pciw_pkg::REG_WIDTH_RST;
         exp_q <= 4'hF;
      end else begin
         if (i_reg_wr && i_reg_addr == pciw_pkg::REG_WIDTH_OFS) width_q <= i_reg_wdata;
         if (take && valid) exp_q <= exp4;
      end
   end
   always_comb begin
      sel = i_acc.sock ? width_q[5:4] : width_q[7:6];
      acc16 = i_acc.sock ? width_q[3] : width_q[2];
      wio = i_acc.sock ? i_sock_b_card_wide_io : i_sock_a_card_wide_io;
      valid = sel == pciw_pkg::SEL_VALID;
      word = i_acc.wide & !wio & acc16 & !i_acc.sys_addr_bit_zero & !i_acc.sys_byte_high_enable_b;
      split = i_acc.wide & !word;
      pair = word ? 2'b00 : (!i_acc.wide && !wio && i_acc.sys_addr_bit_zero) ? 2'b10 : 2'b01;
      exp4 = i_acc.sock ? {2'b11, pair} : {pair, 2'b11};
      take = i_acc.req & o_acc_ready;
      en4 = {o_card.sock_a_low_byte_enable_b, o_card.sock_a_high_byte_enable_b,
             o_card.sock_b_low_byte_enable_b, o_card.sock_b_high_byte_enable_b};
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_lane_select: assert property (take && valid |=> en4 == exp_q)
      else $error("card enables differ from access kind");
   a_split_pair: assert property (take && valid && split |-> ##T1 en4 == 4'hF ##GAP_CYCLES en4 == exp_q
      ##STROBE_CYCLES o_acc_done) else $error("split access timing wrong");
   a_single_done: assert property (take && valid && !split |-> ##T1 o_acc_done && en4 == 4'hF)
      else $error("single access timing wrong");
   a_bad_sel: assert property (take && !valid |=> o_acc_done && o_acc_err && en4 == 4'hF)
      else $error("bad selector not refused");
   a_busy_not_ready: assert property (en4 != 4'hF |-> !o_acc_ready)
      else $error("ready during card cycle");
   a_word_even: assert property (en4[3:2] == 2'b00 || en4[1:0] == 2'b00 |-> !o_card.addr_bit_zero)
      else $error("word cycle at odd address");
   a_err_done: assert property (o_acc_err |-> o_acc_done)
      else $error("error without done");
   a_done_pulse: assert property (o_acc_done |=> !o_acc_done)
      else $error("done longer than one cycle");
   c_split: cover property (take && valid && split);
   c_word: cover property (take && valid && word);
   c_bad: cover property (take && !valid);
endmodule : pciw_top_monitor

bind pciw_top pciw_top_monitor #(.STROBE_CYCLES(STROBE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_mon (.i_clk, .i_rst_b,
   .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_acc, .o_acc_ready, .o_acc_done, .o_acc_err, .i_sock_a_card_wide_io,
   .i_sock_b_card_wide_io, .o_card);

/* File: dv/pciw_card_model.sv */
// Behavioural PC Card answering I/O reads in either socket
`timescale 1ns/1ps
module pciw_card_model (
   input wire logic i_clk,
   input wire pciw_pkg::pciw_card_t i_card,
   output logic [15:0] o_rdata,
   output logic [15:0] o_wr
);
   logic [15:0] last_q = 16'h0000;
   logic [15:0] wr_q = 16'h0000;
   logic sel_b, act, lo_en, hi_en;
   always_comb begin
      lo_en = !(i_card.sock_a_low_byte_enable_b && i_card.sock_b_low_byte_enable_b);
      hi_en = !(i_card.sock_a_high_byte_enable_b && i_card.sock_b_high_byte_enable_b);
      sel_b = !(i_card.sock_b_low_byte_enable_b && i_card.sock_b_high_byte_enable_b);
      act = !i_card.iord_b && (sel_b || !(i_card.sock_a_low_byte_enable_b && i_card.sock_a_high_byte_enable_b));
      // Released bus shows the inverse, so a stale sample never matches
      o_rdata = act ? ((sel_b ? 16'h5AC3 : 16'h3C96) ^ {16{i_card.addr_bit_zero}}) : ~last_q;
   end
   always_ff @(posedge i_clk) last_q <= o_rdata;
   // Byte memory of writes: low lane lands where the address bit points, high lane is always odd
   always_ff @(posedge i_clk) begin
      if (!i_card.iowr_b && lo_en && i_card.addr_bit_zero) wr_q[15:8] <= i_card.wdata[7:0];
      if (!i_card.iowr_b && lo_en && !i_card.addr_bit_zero) wr_q[7:0] <= i_card.wdata[7:0];
      if (!i_card.iowr_b && hi_en) wr_q[15:8] <= i_card.wdata[15:8];
   end
   assign o_wr = wr_q;
endmodule : pciw_card_model

/* File: dv/pc_card_io_width_translator_test.sv */
// Self-checking bench for the card I/O width translator
`timescale 1ns/1ps
module pc_card_io_width_translator_test;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] o_reg_rdata;
   pciw_pkg::pciw_acc_t i_acc = '0;
   logic o_acc_ready, o_acc_done, o_acc_err;
   logic [15:0] o_acc_rdata, i_card_rdata;
   logic [15:0] card_wr;
   logic i_sock_a_card_wide_io = 1'b0;
   logic i_sock_b_card_wide_io = 1'b0;
   pciw_pkg::pciw_card_t o_card;
   int num_errors = 0;
   int checks = 0;
   pciw_top #(.STROBE_CYCLES(2), .GAP_CYCLES(1)) uut (.i_clk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
      .i_reg_rd, .o_reg_rdata, .i_acc, .o_acc_ready, .o_acc_done, .o_acc_err, .o_acc_rdata, .i_sock_a_card_wide_io,
      .i_sock_b_card_wide_io, .i_card_rdata, .o_card);
   pciw_card_model card (.i_clk, .i_card(o_card), .o_rdata(i_card_rdata), .o_wr(card_wr));
   initial forever #10 i_clk = ~i_clk;
   task automatic stop_test();
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] want, input logic [15:0] mask);
      checks++;
      if ((got & mask) !== want) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got & mask, want);
      end
   endtask : chk
   task automatic reg_acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_rd <= rd;
      i_reg_wr <= !rd;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      i_reg_wr <= 1'b0;
      #1;
   endtask : reg_acc
   task automatic access(input logic s, w, wr, a0, bhe, input logic [15:0] d);
      int n;
      @(posedge i_clk);
      i_acc <= '{1'b1, s, w, wr, a0, bhe, d};
      @(posedge i_clk);
      i_acc.req <= 1'b0;
      // Card line moves after the take; decision must not follow it
      {i_sock_a_card_wide_io, i_sock_b_card_wide_io} <= 2'($urandom());
      n = 0;
      #1;
      while (o_acc_done !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask : access
   function automatic logic [15:0] expect_rd(input logic s, w, a0, wrd, wio);
      logic [15:0] c0;
      c0 = s ? 16'h5AC3 : 16'h3C96;
      if (wrd) return c0;
      if (w) return {~c0[7:0], c0[7:0]};
      if (a0 && !wio) return {8'h00, ~c0[15:8]};
      return {8'h00, a0 ? ~c0[7:0] : c0[7:0]};
   endfunction : expect_rd
   function automatic logic [7:0] stat_bits(input logic busy, err, wa, wb);
      logic [7:0] v;
      v = 8'h00;
      v[pciw_pkg::STAT_BUSY_BIT] = busy;
      v[pciw_pkg::STAT_ERR_BIT] = err;
      v[pciw_pkg::STAT_WIDE_A_BIT] = wa;
      v[pciw_pkg::STAT_WIDE_B_BIT] = wb;
      return v;
   endfunction : stat_bits
   initial begin
      logic s, w, a0, bhe, wio, ok, wrd, wr;
      logic [7:0] width, st_exp, st_mask;
      logic [31:0] r;
      logic [15:0] wmask;
      void'($urandom(25));
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk);
      reg_acc(1'b1, pciw_pkg::REG_WIDTH_OFS, 8'h00);
      chk({8'h00, o_reg_rdata}, {8'h00, pciw_pkg::REG_WIDTH_RST}, 16'h00FF);
      reg_acc(1'b1, 8'h3C, 8'h00);
      chk({8'h00, o_reg_rdata}, 16'h0000, 16'h00FF);
      for (int i = 0; i < 80; i++) begin
         r = $urandom();
         // First sixteen walk every socket, width, parity and card kind
         width = i < 16 ? 8'hAC : {(r[1:0] == 0 ? r[3:2] : 2'b10), (r[5:4] == 0 ? r[7:6] : 2'b10), r[11:8]};
         {s, w, a0, wio} = i < 16 ? 4'(i) : r[15:12];
         bhe = i < 16 ? 1'b0 : r[16];
         wr = i < 16 ? 1'b0 : r[17];
         reg_acc(1'b0, pciw_pkg::REG_WIDTH_OFS, width);
         reg_acc(1'b1, pciw_pkg::REG_WIDTH_OFS, 8'h00);
         chk({8'h00, o_reg_rdata}, {8'h00, width}, 16'h00FF);
         ok = (s ? width[5:4] : width[7:6]) == pciw_pkg::SEL_VALID;
         wrd = w & !wio & (s ? width[3] : width[2]) & !a0 & !bhe;
         @(posedge i_clk);
         {i_sock_a_card_wide_io, i_sock_b_card_wide_io} <= s ? {r[20], wio} : {wio, r[20]};
         access(s, w, wr, a0, bhe, r[31:16]);
         chk({14'h0, o_acc_done, o_acc_err}, {14'h0, 1'b1, !ok}, 16'h0003);
         if (ok && !wr) chk(o_acc_rdata, expect_rd(s, w, a0, wrd, wio), w ? 16'hFFFF : 16'h00FF);
         wmask = w ? 16'hFFFF : a0 ? 16'hFF00 : 16'h00FF;
         if (ok && wr) chk(card_wr, (w ? r[31:16] : {2{r[23:16]}}) & wmask, wmask);
         // Sticky error must show exactly the last refusal, then clear by writing one
         st_exp = stat_bits(1'b0, !ok, i_sock_a_card_wide_io, i_sock_b_card_wide_io);
         st_mask = stat_bits(1'b1, 1'b1, 1'b1, 1'b1);
         reg_acc(1'b1, pciw_pkg::REG_STAT_OFS, 8'h00);
         chk({8'h00, o_reg_rdata}, {8'h00, st_exp}, {8'h00, st_mask});
         if (!ok) reg_acc(1'b0, pciw_pkg::REG_STAT_OFS, stat_bits(1'b0, 1'b1, 1'b0, 1'b0));
      end
      stop_test();
   end
   // About fifteen times the expected run length
   initial begin
      #300000;
      num_errors++;
      stop_test();
   end
endmodule : pc_card_io_width_translator_test
